// *** inc/cmbr_pkg.sv ***
/*
  Shared constants and types for the chain-mode readout of a 14-bit
  sampling converter with busy indicator.
  Assumes a single 10 MHz system clock; all pins are asynchronous to it.
*/
// Operation
// - With chain input and convert strobe both low, the serial output is driven low.
// - A convert strobe rise while the shift clock is high starts a conversion in chain mode with the busy indicator on.
// - When all converters in the chain are done, the near-end serial output is driven high.
// - After completion the device is in acquisition with its converter powered down until the next start.
// - The result leaves on the serial output MSB first, one bit per shift clock falling edge.
// - Each shift clock falling edge after the one that retires the marker loads the chain input into the shift register input end.
`default_nettype none

package cmbr_pkg;

  localparam int unsigned DATA_W        = 14;
  localparam int unsigned CONV_DIV      = 4;
  localparam int unsigned CONV_TICKS    = 16;
  localparam int unsigned DIV_W         = 8;
  localparam int unsigned TICK_W        = 8;
  localparam logic [DATA_W-1:0] SREG_RST = 14'h0000;

  typedef enum logic [1:0] {
    CMBR_IDLE    = 2'b00,
    CMBR_CONVERT = 2'b01,
    CMBR_MARK    = 2'b10,
    CMBR_READ    = 2'b11
  } cmbr_state_t;

  typedef struct packed {
    logic convert_strobe;
    logic shift_clock;
    logic chain_input;
  } cmbr_pins_t;

endpackage

`default_nettype wire

// *** rtl/cmbr_conv_timer.sv ***
/*
  Conversion timer: an internal conversion clock enable from a divider,
  and a count of its ticks that ends in a one-cycle done pulse.
  Assumes start is a one-cycle pulse on clk and abort ends the frame.
*/
`timescale 1ns/1ns
`default_nettype none

module cmbr_conv_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      running,
  output logic      done
);

  logic [cmbr_pkg::DIV_W-1:0]  div_reg;
  logic [cmbr_pkg::TICK_W-1:0] tick_reg;
  logic                        run_reg;
  logic                        done_reg;
  wire  logic                  conv_en;
  wire  logic                  last_tick;

  // Divider runs only while converting so the converter draws nothing idle
  assign conv_en   = run_reg &&
                     (div_reg == cmbr_pkg::DIV_W'(cmbr_pkg::CONV_DIV - 1));
  assign last_tick = conv_en &&
                     (tick_reg == cmbr_pkg::TICK_W'(cmbr_pkg::CONV_TICKS - 1));
  assign running   = run_reg;
  assign done      = done_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= '0;
      tick_reg <= '0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= last_tick && !abort;
      if (start) begin
        run_reg  <= 1'b1;
        div_reg  <= '0;
        tick_reg <= '0;
      end else if (abort || last_tick) begin
        run_reg  <= 1'b0;
      end else if (run_reg) begin
        div_reg <= conv_en ? '0 : div_reg + 1'b1;
        if (conv_en) begin
          tick_reg <= tick_reg + 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/cmbr_chain.sv ***
/*
  Chain-mode converter readout with busy indicator: start detection,
  conversion timing, busy marker and the 14-bit chain shift register.
  Assumes the pins arrive asynchronously and the analog core presents a
  stable code on sample_code at the start of every conversion.
*/
`timescale 1ns/1ns
`default_nettype none

module cmbr_chain (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Pins from the host and the upstream converter
  input  wire cmbr_pkg::cmbr_pins_t        pins,
  // Analog core
  input  wire logic [cmbr_pkg::DATA_W-1:0] sample_code,
  output logic                             sample_take,
  // Serial output pin
  output logic                             serial_output,
  output logic                             serial_output_oe,
  // Status
  output logic                             converting,
  output logic                             powered_down
);

  cmbr_pkg::cmbr_pins_t        meta_reg;
  cmbr_pkg::cmbr_pins_t        sync_reg;
  cmbr_pkg::cmbr_pins_t        prev_reg;
  cmbr_pkg::cmbr_state_t       state_reg;
  cmbr_pkg::cmbr_state_t       state_next;
  logic [cmbr_pkg::DATA_W-1:0] code_reg;
  logic [cmbr_pkg::DATA_W-1:0] sreg_reg;
  logic [cmbr_pkg::DATA_W-1:0] sreg_next;
  logic                        sdo_reg;
  logic                        sdo_next;
  logic                        oe_reg;
  logic                        oe_next;
  logic                        take_reg;
  logic                        pd_reg;
  logic                        meta_ok_reg;
  logic                        sync_ok_reg;
  logic                        prev_ok_reg;
  logic [cmbr_pkg::DATA_W-1:0] sreg_shifted;
  wire  logic                  cnv_s;
  wire  logic                  sck_s;
  wire  logic                  sdi_s;
  wire  logic                  cnv_rise;
  wire  logic                  cnv_low;
  wire  logic                  sck_fall;
  wire  logic                  start;
  wire  logic                  conv_done;
  wire  logic                  timer_running;
  wire  logic                  edges_ok;
  wire  logic                  idle_oe;
  wire  logic                  sreg_top;
  wire  logic                  sreg_second;

  // Two-stage synchronisers; sync_reg and the edge-history prev_reg are read by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges count only once prev_reg holds a real pin sample, so a strobe
  // already high through reset is never taken for a rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ok_reg <= 1'b0;
      sync_ok_reg <= 1'b0;
      prev_ok_reg <= 1'b0;
    end else begin
      meta_ok_reg <= 1'b1;
      sync_ok_reg <= meta_ok_reg;
      prev_ok_reg <= sync_ok_reg;
    end
  end

  assign cnv_s    = sync_reg.convert_strobe;
  assign sck_s    = sync_reg.shift_clock;
  assign sdi_s    = sync_reg.chain_input;
  assign edges_ok = prev_ok_reg;
  assign cnv_rise = edges_ok && cnv_s && !prev_reg.convert_strobe;
  assign cnv_low  = !cnv_s;
  assign sck_fall = edges_ok && !sck_s && prev_reg.shift_clock;

  // Outside a frame the pin is released while the upstream line is high
  // and driven low otherwise, so the chain never floats to a false marker
  function automatic logic idle_drive(input logic upstream);
    return !upstream;
  endfunction

  // Shift path selections used by the state machine
  assign idle_oe      = idle_drive(sdi_s);
  assign sreg_top     = sreg_reg[cmbr_pkg::DATA_W-1];
  assign sreg_second  = sreg_reg[cmbr_pkg::DATA_W-2];
  assign sreg_shifted = {sreg_reg[cmbr_pkg::DATA_W-2:0], sdi_s};

  // Both levels come from the same synchroniser stage: the shift clock
  // must already stand high when the strobe rise is seen
  assign start = (state_reg == cmbr_pkg::CMBR_IDLE) && cnv_rise &&
                 sck_s;

  cmbr_conv_timer i_cmbr_conv_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (start),
    .abort   (cnv_low),
    .running (timer_running),
    .done    (conv_done)
  );

  always_comb begin
    // Defaults: line low and released, nothing shifts
    state_next = state_reg;
    sreg_next  = sreg_reg;
    sdo_next   = 1'b0;
    oe_next    = 1'b0;
    unique case (state_reg)
      cmbr_pkg::CMBR_IDLE: begin
        oe_next  = idle_oe;
        sdo_next = 1'b0;
        if (start) begin
          state_next = cmbr_pkg::CMBR_CONVERT;
          oe_next    = 1'b1;
        end
      end
      cmbr_pkg::CMBR_CONVERT: begin
        // Busy: hold the line low so downstream sees not-ready
        oe_next  = 1'b1;
        sdo_next = 1'b0;
        if (cnv_low) begin
          state_next = cmbr_pkg::CMBR_IDLE;
          oe_next    = idle_oe;
        end else if (conv_done) begin
          state_next = cmbr_pkg::CMBR_MARK;
          sreg_next  = code_reg;
          sdo_next   = sdi_s;
        end
      end
      cmbr_pkg::CMBR_MARK: begin
        // Marker goes high only once every upstream part is done
        oe_next  = 1'b1;
        sdo_next = sdi_s;
        if (cnv_low) begin
          state_next = cmbr_pkg::CMBR_IDLE;
          oe_next    = idle_oe;
          sdo_next   = 1'b0;
        end else if (sck_fall) begin
          // First falling edge only retires the marker: 14N+1 clocks
          state_next = cmbr_pkg::CMBR_READ;
          sdo_next   = sreg_top;
        end
      end
      cmbr_pkg::CMBR_READ: begin
        oe_next  = 1'b1;
        sdo_next = sreg_top;
        if (cnv_low) begin
          state_next = cmbr_pkg::CMBR_IDLE;
          oe_next    = idle_oe;
          sdo_next   = 1'b0;
        end else if (sck_fall) begin
          sreg_next = sreg_shifted;
          sdo_next  = sreg_second;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cmbr_pkg::CMBR_IDLE;
      sreg_reg  <= cmbr_pkg::SREG_RST;
      sdo_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      sreg_reg  <= sreg_next;
      sdo_reg   <= sdo_next;
      oe_reg    <= oe_next;
    end
  end

  // Sample is taken at the conversion start edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= cmbr_pkg::SREG_RST;
      take_reg <= 1'b0;
    end else begin
      take_reg <= start;
      if (start) begin
        code_reg <= sample_code;
      end
    end
  end

  // Acquisition phase: core powered down from completion to next start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_reg <= 1'b1;
    end else if (start) begin
      pd_reg <= 1'b0;
    end else if (conv_done || !timer_running) begin
      pd_reg <= 1'b1;
    end
  end

  // Every pin and status output comes straight from a flop
  assign serial_output    = sdo_reg;
  assign serial_output_oe = oe_reg;
  assign sample_take      = take_reg;
  assign converting       = timer_running;
  assign powered_down     = pd_reg;

endmodule

`default_nettype wire

// *** tb/cmbr_chain_monitor.sv ***
/* Checker on the cmbr_chain ports.
   Bound in from the bench top; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module cmbr_chain_monitor (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Pins and outputs
  input wire cmbr_pkg::cmbr_pins_t pins,
  input wire logic                 sample_take,
  input wire logic                 serial_output,
  input wire logic                 serial_output_oe,
  input wire logic                 converting,
  input wire logic                 powered_down
);
  wire        cs = pins.convert_strobe;
  wire        sck = pins.shift_clock;
  wire        ci = pins.chain_input;
  logic [7:0] conv_cnt_reg;
  logic [3:0] fall_age_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Age saturates so a long idle span never wraps into a false match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_reg <= 8'h00;
      fall_age_reg <= 4'hf;
    end else begin
      conv_cnt_reg <= converting ? conv_cnt_reg + 8'h01 : 8'h00;
      fall_age_reg <= $fell(sck) ? 4'h0 :
                      fall_age_reg + {3'h0, fall_age_reg != 4'hf};
    end
  end
  AST_IDLE_LOW: assert property (
    (!cs && !ci)[*6] |-> serial_output_oe && !serial_output)
    else $error("idle line not low");
  AST_NO_START: assert property (
    (!sck[*3] ##0 $rose(cs)) ##1 !sck[*4] |-> !converting)
    else $error("start with shift clock low");
  AST_START: assert property (
    (sck[*4] ##0 $rose(cs)) ##1 (cs && sck)[*6] |-> converting &&
    serial_output_oe && !serial_output && !powered_down)
    else $error("conversion not started");
  AST_CONV_MIN: assert property (
    $fell(converting) && cs |->
    conv_cnt_reg >= cmbr_pkg::CONV_DIV * cmbr_pkg::CONV_TICKS)
    else $error("conversion too short");
  AST_MARK: assert property (
    $fell(converting) && cs && ci |->
    ##[0:2] serial_output_oe && serial_output)
    else $error("completion marker missing");
  AST_PWRDN: assert property (
    $fell(converting) && cs |-> ##[0:2] powered_down[*3])
    else $error("no power down");
  AST_SHIFT: assert property (
    cs && $past(cs, 4) && !converting && !$past(converting, 3) &&
    $changed(serial_output) |-> fall_age_reg <= 4'h6)
    else $error("output moved without a fall");
  AST_TAKE: assert property (sample_take |-> ##[0:1] converting)
    else $error("sample without conversion");
  cover property ($fell(converting) && cs);
  cover property ($rose(cs) && !sck);
  cover property (cs && $fell(sck) && !converting);
endmodule
`default_nettype wire

// *** tb/cmbr_host_model.sv ***
/* Host model: strobe, shift clock and an upstream chain input.
   Assumes clk is the bench clock; reads the serial line. */
`timescale 1ns/1ns
`default_nettype none
module cmbr_host_model (
  // Clock
  input  wire logic                clk,
  // Pins and serial line
  output var cmbr_pkg::cmbr_pins_t pins,
  input  wire logic                serial_output,
  input  wire logic                serial_output_oe
);
  logic line_q = 1'b0;
  // A released line toggles so a stale bit can never pass as data
  wire  line = serial_output_oe ? serial_output : !line_q;
  initial pins = 3'h2;
  always @(posedge clk) line_q <= line;
  task automatic drive(input logic [2:0] v, input int n);
    pins <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic frame(input logic [13:0] up, output logic [27:0] got,
                       output int lat);
    got = 28'h0;
    drive(3'h3, 6);
    drive(3'h7, 8);
    lat = 8;
    while (!line && lat < 200) begin
      @(posedge clk);
      lat++;
    end
    for (int j = 1; j <= 29; j++) begin
      drive({2'h2, pins.chain_input}, 4);
      drive({2'h3, (j <= 14) ? up[14-j] : pins.chain_input}, 4);
      if (j < 29) got = {got[26:0], line};
    end
    drive(3'h2, 8);
  endtask
endmodule
`default_nettype wire

// *** tb/cmbr_chain_tb_top.sv ***
/* Bench top: host model, random chain frames and start corner cases.
   Assumes the monitor and host model are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module cmbr_chain_tb_top;
  logic                       clk;
  logic                       rst_n;
  logic [13:0]                code;
  logic [13:0]                up;
  logic [15:0]                seed = 16'h003c;
  logic [27:0]                got;
  int                         lat;
  int                         error_cnt = 0;
  int                         check_count = 0;
  wire cmbr_pkg::cmbr_pins_t  pins;
  logic                       sample_take;
  logic                       serial_output;
  logic                       serial_output_oe;
  logic                       converting;
  logic                       powered_down;
  cmbr_chain i_cmbr_chain (.clk(clk), .rst_n(rst_n), .pins(pins),
    .sample_code(code), .sample_take(sample_take),
    .serial_output(serial_output), .serial_output_oe(serial_output_oe),
    .converting(converting), .powered_down(powered_down));
  cmbr_host_model i_cmbr_host_model (.clk(clk), .pins(pins),
    .serial_output(serial_output), .serial_output_oe(serial_output_oe));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [27:0] chain_word(input logic [13:0] c, u);
    return {c, u};
  endfunction
  task automatic chk_val(input logic [27:0] a, e);
    check_count++;
    if (a !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, a, e);
    end
  endtask
  task automatic chk_lat(input int a, lo, hi);
    check_count++;
    if (a < lo || a > hi) begin
      error_cnt++;
      $display("MISMATCH %0t latency %0d", $time, a);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #500000;
    error_cnt++;
    finish_test;
  end
  initial begin
    rst_n = 1'b0;
    code = 14'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    i_cmbr_host_model.drive(3'h2, 8);
    chk_val(28'({serial_output_oe, serial_output}), 28'h2);
    i_cmbr_host_model.drive(3'h1, 6);
    i_cmbr_host_model.drive(3'h5, 12);
    chk_val(28'(converting), 28'h0);
    i_cmbr_host_model.drive(3'h3, 6);
    i_cmbr_host_model.drive(3'h7, 12);
    chk_val(28'({converting, powered_down}), 28'h2);
    i_cmbr_host_model.drive(3'h2, 8);
    chk_val(28'({converting, serial_output}), 28'h0);
    // First frame: full-scale code against an all-zero upstream word
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      code <= (i == 0) ? 14'h3fff : seed[13:0];
      seed = lfsr(seed);
      up = (i == 0) ? 14'h0000 : seed[13:0];
      i_cmbr_host_model.frame(up, got, lat);
      chk_val(got, chain_word(code, up));
      chk_lat(lat, cmbr_pkg::CONV_DIV * cmbr_pkg::CONV_TICKS, 90);
      chk_val(28'(powered_down), 28'h1);
    end
    finish_test;
  end
endmodule
bind cmbr_chain cmbr_chain_monitor i_cmbr_chain_monitor (
  .clk(clk), .rst_n(rst_n), .pins(pins), .sample_take(sample_take),
  .serial_output(serial_output), .serial_output_oe(serial_output_oe),
  .converting(converting), .powered_down(powered_down));
`default_nettype wire
